// ===== shared/ufb_pkg.sv
// Package with register map, field layout, reset values and shared types of the flag and divisor block.
package ufb_pkg;

  // ===========================================================================
  // Register offsets (byte addresses)
  // ===========================================================================
  localparam logic [11:0] UFB_OFF_LINE_FLAGS   = 12'h018;
  localparam logic [11:0] UFB_OFF_DIV_INTEGER  = 12'h024;
  localparam logic [11:0] UFB_OFF_DIV_FRACTION = 12'h028;
  localparam logic [11:0] UFB_OFF_FRAME_CTRL   = 12'h02c;
  localparam logic [11:0] UFB_OFF_IRQ_STATUS   = 12'h040;
  localparam logic [11:0] UFB_OFF_IRQ_MASK     = 12'h044;

  // ===========================================================================
  // Flag register bit positions
  // ===========================================================================
  localparam int UFB_BIT_TX_EMPTY = 7;
  localparam int UFB_BIT_RX_FULL  = 6;
  localparam int UFB_BIT_TX_FULL  = 5;
  localparam int UFB_BIT_RX_EMPTY = 4;
  localparam int UFB_BIT_BUSY     = 3;

  // Frame control fields.
  localparam int UFB_BIT_STICK    = 7;
  localparam int UFB_POS_WLEN     = 5;
  localparam int UFB_BIT_FIFO_EN  = 4;
  localparam int UFB_BIT_STOP2    = 3;
  localparam int UFB_BIT_EVEN     = 2;
  localparam int UFB_BIT_PAR_EN   = 1;
  localparam int UFB_BIT_BREAK    = 0;

  // Interrupt status bit positions.
  localparam int UFB_IRQ_TX_DONE  = 0;
  localparam int UFB_IRQ_RX_DONE  = 1;
  localparam int UFB_IRQ_OVERRUN  = 2;
  localparam int UFB_IRQ_WIDTH    = 3;

  // ===========================================================================
  // Reset values and widths
  // ===========================================================================
  localparam logic [7:0]  UFB_RST_FLAGS      = 8'h90;
  localparam logic [15:0] UFB_RST_DIV_INT    = 16'h0000;
  localparam logic [5:0]  UFB_RST_DIV_FRAC   = 6'h00;
  localparam logic [7:0]  UFB_RST_FRAME_CTRL = 8'h00;
  localparam int          UFB_DIV_INT_W      = 16;
  localparam int          UFB_DIV_FRAC_W     = 6;
  localparam int          UFB_OVERSAMPLE     = 16;
  localparam int          UFB_FIFO_DEPTH     = 16;
  localparam logic [1:0]  UFB_RESP_OKAY      = 2'b00;
  localparam logic [1:0]  UFB_RESP_SLVERR    = 2'b10;

  // ===========================================================================
  // Shared types
  // ===========================================================================
  typedef struct packed {
    logic [15:0] int_part;
    logic [5:0]  frac_part;
  } ufb_divisor_type;

  typedef struct packed {
    logic       tx_empty_flag;
    logic       rx_full_flag;
    logic       tx_full_flag;
    logic       rx_empty_flag;
    logic       busy;
  } ufb_flags_type;

  typedef enum logic [1:0] {
    UFB_TX_IDLE  = 2'b00,
    UFB_TX_SHIFT = 2'b01,
    UFB_TX_STOP  = 2'b10
  } ufb_tx_state_type;

endpackage

// ===== src/ufb_fifo_mem.sv
// Small byte memory with registered read data, used for the transmit and receive FIFOs.
`timescale 1ns/1ps
module ufb_fifo_mem
  import ufb_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock.
  input  wire logic             clk_in,
  // Write port.
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Read port.
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule

// ===== src/ufb_top.sv
// Serial port flag register, baud divisor, frame control, FIFOs, transmitter and receiver.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module ufb_top
  import ufb_pkg::*;
#(
  parameter int FIFO_DEPTH = UFB_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  // AXI4-Lite write address and data.
  input  wire logic [11:0] S_AWADDR_IN,
  input  wire logic        S_AWVALID_IN,
  output logic             S_AWREADY_OUT,
  input  wire logic [31:0] S_WDATA_IN,
  input  wire logic [3:0]  S_WSTRB_IN,
  input  wire logic        S_WVALID_IN,
  output logic             S_WREADY_OUT,
  // AXI4-Lite write response.
  output logic [1:0]       S_BRESP_OUT,
  output logic             S_BVALID_OUT,
  input  wire logic        S_BREADY_IN,
  // AXI4-Lite read.
  input  wire logic [11:0] S_ARADDR_IN,
  input  wire logic        S_ARVALID_IN,
  output logic             S_ARREADY_OUT,
  output logic [31:0]      S_RDATA_OUT,
  output logic [1:0]       S_RRESP_OUT,
  output logic             S_RVALID_OUT,
  input  wire logic        S_RREADY_IN,
  // Transmit data stream in.
  input  wire logic [7:0]  TX_DATA_IN,
  input  wire logic        TX_VALID_IN,
  output logic             TX_READY_OUT,
  // Receive data stream out.
  output logic [7:0]       RX_DATA_OUT,
  output logic             RX_VALID_OUT,
  input  wire logic        RX_READY_IN,
  // Serial line and interrupt.
  input  wire logic        SER_RX_IN,
  output logic             SER_TX_OUT,
  output logic             IRQ_OUT
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(FIFO_DEPTH);

  // ===========================================================================
  // Register storage
  // ===========================================================================
  logic [15:0]          div_int_q;
  logic [5:0]           div_frac_q;
  ufb_divisor_type      div_commit_q;
  ufb_divisor_type      div_active_q;
  logic                 div_pending_q;
  logic [7:0]           frame_ctrl_q;
  logic [UFB_IRQ_WIDTH-1:0] irq_stat_q;
  logic [UFB_IRQ_WIDTH-1:0] irq_mask_q;
  ufb_flags_type        flags;
  logic                 fifo_en;
  logic                 ev_tx_done;
  logic                 ev_rx_done;
  logic                 ev_overrun;
  logic                 char_idle;

  assign fifo_en = frame_ctrl_q[UFB_BIT_FIFO_EN];

  // ===========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  // ===========================================================================
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_do;

  assign wr_do = aw_held_q && w_held_q && !S_BVALID_OUT;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      S_AWREADY_OUT <= 1'b0;
      S_WREADY_OUT  <= 1'b0;
      S_BVALID_OUT  <= 1'b0;
      S_BRESP_OUT   <= UFB_RESP_OKAY;
    end else begin
      S_AWREADY_OUT <= !aw_held_q && !S_AWREADY_OUT && !S_BVALID_OUT;
      S_WREADY_OUT  <= !w_held_q && !S_WREADY_OUT && !S_BVALID_OUT;
      if (S_AWVALID_IN && S_AWREADY_OUT) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AWADDR_IN;
        S_AWREADY_OUT <= 1'b0;
      end
      if (S_WVALID_IN && S_WREADY_OUT) begin
        w_held_q <= 1'b1;
        w_data_q <= S_WDATA_IN;
        w_strb_q <= S_WSTRB_IN;
        S_WREADY_OUT <= 1'b0;
      end
      if (wr_do) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        S_BVALID_OUT <= 1'b1;
        case (aw_addr_q)
          UFB_OFF_DIV_INTEGER, UFB_OFF_DIV_FRACTION, UFB_OFF_FRAME_CTRL,
          UFB_OFF_IRQ_STATUS, UFB_OFF_IRQ_MASK: S_BRESP_OUT <= UFB_RESP_OKAY;
          default: S_BRESP_OUT <= UFB_RESP_SLVERR;
        endcase
      end else if (S_BVALID_OUT && S_BREADY_IN) begin
        S_BVALID_OUT <= 1'b0;
      end
    end
  end

  // Register writes honour byte strobes.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      div_int_q    <= UFB_RST_DIV_INT;
      div_frac_q   <= UFB_RST_DIV_FRAC;
      frame_ctrl_q <= UFB_RST_FRAME_CTRL;
      irq_mask_q   <= '0;
    end else if (wr_do) begin
      case (aw_addr_q)
        UFB_OFF_DIV_INTEGER: begin
          if (w_strb_q[0]) div_int_q[7:0]  <= w_data_q[7:0];
          if (w_strb_q[1]) div_int_q[15:8] <= w_data_q[15:8];
        end
        UFB_OFF_DIV_FRACTION: begin
          if (w_strb_q[0]) div_frac_q <= w_data_q[5:0];
        end
        UFB_OFF_FRAME_CTRL: begin
          if (w_strb_q[0]) frame_ctrl_q <= w_data_q[7:0];
        end
        UFB_OFF_IRQ_MASK: begin
          if (w_strb_q[0]) irq_mask_q <= w_data_q[UFB_IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Divisor commits on the frame control strobe, then waits for an idle character.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      div_commit_q  <= '{int_part: UFB_RST_DIV_INT, frac_part: UFB_RST_DIV_FRAC};
      div_active_q  <= '{int_part: UFB_RST_DIV_INT, frac_part: UFB_RST_DIV_FRAC};
      div_pending_q <= 1'b0;
    end else begin
      if (wr_do && aw_addr_q == UFB_OFF_FRAME_CTRL) begin
        div_commit_q  <= '{int_part: div_int_q, frac_part: div_frac_q};
        div_pending_q <= 1'b1;
      end else if (div_pending_q && char_idle) begin
        div_active_q  <= div_commit_q;
        div_pending_q <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // AXI4-Lite read channel
  // ===========================================================================
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      S_ARREADY_OUT <= 1'b0;
      S_RVALID_OUT  <= 1'b0;
      S_RDATA_OUT   <= 32'h0000_0000;
      S_RRESP_OUT   <= UFB_RESP_OKAY;
    end else begin
      S_ARREADY_OUT <= !S_ARREADY_OUT && !S_RVALID_OUT;
      if (S_ARVALID_IN && S_ARREADY_OUT) begin
        S_ARREADY_OUT <= 1'b0;
        S_RVALID_OUT  <= 1'b1;
        S_RRESP_OUT   <= UFB_RESP_OKAY;
        case (S_ARADDR_IN)
          UFB_OFF_LINE_FLAGS:   S_RDATA_OUT <= {24'h0, flags, 3'b000};
          UFB_OFF_DIV_INTEGER:  S_RDATA_OUT <= {16'h0, div_int_q};
          UFB_OFF_DIV_FRACTION: S_RDATA_OUT <= {26'h0, div_frac_q};
          UFB_OFF_FRAME_CTRL:   S_RDATA_OUT <= {24'h0, frame_ctrl_q};
          UFB_OFF_IRQ_STATUS:   S_RDATA_OUT <= {29'h0, irq_stat_q};
          UFB_OFF_IRQ_MASK:     S_RDATA_OUT <= {29'h0, irq_mask_q};
          default: begin
            S_RDATA_OUT <= 32'h0000_0000;
            S_RRESP_OUT <= UFB_RESP_SLVERR;
          end
        endcase
      end else if (S_RVALID_OUT && S_RREADY_IN) begin
        S_RVALID_OUT <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Baud tick generator, sixteen ticks per bit
  // ===========================================================================
  logic [15:0] tick_cnt_q;
  logic [6:0]  frac_acc_q;
  logic [15:0] tick_limit;
  logic        tick_q;
  logic [6:0]  frac_sum;

  assign frac_sum   = {1'b0, frac_acc_q[5:0]} + {1'b0, div_active_q.frac_part};
  // Zero integer divisor falls back to the minimum ratio of one.
  assign tick_limit = (div_active_q.int_part == 16'h0000) ? 16'h0001
                                                           : div_active_q.int_part;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      tick_cnt_q <= 16'h0000;
      frac_acc_q <= 7'h00;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      // The fractional carry stretches one period by a clock, averaging int + frac/64.
      if ({1'b0, tick_cnt_q} + 17'h00001 >= {1'b0, tick_limit} + {16'h0000, frac_acc_q[6]}) begin
        tick_cnt_q <= 16'h0000;
        tick_q     <= 1'b1;
        frac_acc_q <= frac_sum;
      end else begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
    end
  end

  // ===========================================================================
  // Transmit and receive FIFOs, one entry deep in character mode
  // ===========================================================================
  logic [AW:0]   cap;
  logic [AW:0]   tx_cnt_q;
  logic [AW:0]   rx_cnt_q;
  logic [AW-1:0] tx_wp_q;
  logic [AW-1:0] tx_rp_q;
  logic [AW-1:0] rx_wp_q;
  logic [AW-1:0] rx_rp_q;
  logic [7:0]    tx_rd_data;
  logic [7:0]    rx_rd_data;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_push;
  logic          rx_pop;
  logic [7:0]    rx_shift_q;

  assign cap = fifo_en ? DEPTH_CNT : {{AW{1'b0}}, 1'b1};

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      tx_cnt_q <= '0;
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      rx_cnt_q <= '0;
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop)  tx_rp_q <= tx_rp_q + 1'b1;
      tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      if (rx_push) rx_wp_q <= rx_wp_q + 1'b1;
      if (rx_pop)  rx_rp_q <= rx_rp_q + 1'b1;
      rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  ufb_fifo_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(AW)) u_tx_mem (
    .clk_in      (CLK_SYS_IN),
    .wr_en_in    (tx_push),
    .wr_addr_in  (tx_wp_q),
    .wr_data_in  (TX_DATA_IN),
    .rd_addr_in  (tx_rp_q),
    .rd_data_out (tx_rd_data)
  );

  ufb_fifo_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(AW)) u_rx_mem (
    .clk_in      (CLK_SYS_IN),
    .wr_en_in    (rx_push),
    .wr_addr_in  (rx_wp_q),
    .wr_data_in  (rx_shift_q),
    .rd_addr_in  (rx_rp_q),
    .rd_data_out (rx_rd_data)
  );

  // ===========================================================================
  // Transmitter
  // ===========================================================================
  ufb_tx_state_type tx_state_q;
  logic [3:0]  tx_sub_q;
  logic [3:0]  tx_bit_q;
  logic [3:0]  tx_nbits_q;
  logic [10:0] tx_frame_q;
  logic        tx_load_q;
  logic [3:0]  data_bits;
  logic        par_bit;

  assign data_bits = 4'h5 + {2'b00, frame_ctrl_q[UFB_POS_WLEN +: 2]};
  assign tx_pop    = tx_state_q == UFB_TX_IDLE && tx_cnt_q != '0 && !tx_load_q;
  // Parity over the selected data length, with stick parity forcing a constant level.
  always_comb begin
    par_bit = !frame_ctrl_q[UFB_BIT_EVEN];
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < data_bits) par_bit = par_bit ^ tx_rd_data[i];
    end
    if (frame_ctrl_q[UFB_BIT_STICK]) par_bit = !frame_ctrl_q[UFB_BIT_EVEN];
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      tx_state_q <= UFB_TX_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 4'h0;
      tx_nbits_q <= 4'h0;
      tx_frame_q <= 11'h7ff;
      tx_load_q  <= 1'b0;
      SER_TX_OUT <= 1'b1;
    end else begin
      tx_load_q <= tx_pop;
      case (tx_state_q)
        UFB_TX_IDLE: begin
          SER_TX_OUT <= !frame_ctrl_q[UFB_BIT_BREAK];
          if (tx_load_q) begin
            // Frame: start, data, optional parity, then stop bits shifted in last.
            tx_frame_q <= ({2'b11, 8'hff, 1'b0} & ~(11'h1fe & ~({2'h0, tx_rd_data, 1'b0} |
                          (11'h7fe << data_bits)))) | (11'h7ff << (data_bits + 4'h1));
            if (frame_ctrl_q[UFB_BIT_PAR_EN]) begin
              tx_frame_q[data_bits + 4'h1] <= par_bit;
            end
            tx_nbits_q <= data_bits + 4'h2 + {3'h0, frame_ctrl_q[UFB_BIT_PAR_EN]}
                          + {3'h0, frame_ctrl_q[UFB_BIT_STOP2]};
            tx_bit_q   <= 4'h0;
            tx_sub_q   <= 4'h0;
            tx_state_q <= UFB_TX_SHIFT;
          end
        end
        UFB_TX_SHIFT: begin
          // The line changes only on a tick, so every bit, the start bit too, lasts sixteen whole ticks.
          if (tick_q) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == 4'h0) begin
              SER_TX_OUT <= tx_frame_q[0];
              if (tx_bit_q == tx_nbits_q) tx_state_q <= UFB_TX_STOP;
            end
            if (tx_sub_q == 4'hf) begin
              tx_frame_q <= {1'b1, tx_frame_q[10:1]};
              tx_bit_q   <= tx_bit_q + 4'h1;
            end
          end
        end
        UFB_TX_STOP: begin
          tx_state_q <= UFB_TX_IDLE;
        end
        default: tx_state_q <= UFB_TX_IDLE;
      endcase
    end
  end

  assign tx_push      = TX_VALID_IN && TX_READY_OUT;
  assign ev_tx_done   = tx_state_q == UFB_TX_STOP;

  // ===========================================================================
  // Receiver: start detect at mid-bit, then sample each bit centre
  // ===========================================================================
  logic       rx_act_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_bit_q;
  logic       rx_done_q;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      rx_act_q   <= 1'b0;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_done_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_act_q) begin
        rx_sub_q <= 4'h0;
        rx_bit_q <= 4'h0;
        if (tick_q && !SER_RX_IN) rx_act_q <= 1'b1;
      end else if (tick_q) begin
        rx_sub_q <= rx_sub_q + 4'h1;
        if (rx_sub_q == 4'h7) begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && SER_RX_IN) begin
            rx_act_q <= 1'b0;
          end else if (rx_bit_q >= 4'h1 && rx_bit_q <= data_bits) begin
            rx_shift_q <= {SER_RX_IN, rx_shift_q[7:1]};
          end else if (rx_bit_q > data_bits + {3'h0, frame_ctrl_q[UFB_BIT_PAR_EN]}) begin
            // Short characters arrive at the top of the shifter and are right-aligned once.
            rx_shift_q <= rx_shift_q >> (4'h8 - data_bits);
            rx_act_q  <= 1'b0;
            rx_done_q <= 1'b1;
          end
        end
      end
    end
  end

  logic        rx_pop_q;
  logic [AW:0] rx_occ;

  // A byte waiting at the stream port is still held, so character mode keeps a single byte.
  assign rx_occ     = rx_cnt_q + (AW+1)'(RX_VALID_OUT || rx_pop_q);
  assign rx_push    = rx_done_q && rx_occ < cap;
  assign ev_overrun = rx_done_q && rx_occ >= cap;
  assign ev_rx_done = rx_done_q;
  assign char_idle  = tx_state_q == UFB_TX_IDLE && !tx_load_q && !rx_act_q;
  assign rx_pop     = rx_cnt_q != '0 && !RX_VALID_OUT && !rx_pop_q;

  // ===========================================================================
  // Stream ports, flags and interrupt, all registered
  // ===========================================================================
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      rx_pop_q     <= 1'b0;
      RX_VALID_OUT <= 1'b0;
      RX_DATA_OUT  <= 8'h00;
      TX_READY_OUT <= 1'b0;
    end else begin
      rx_pop_q <= rx_pop;
      if (rx_pop_q) begin
        RX_VALID_OUT <= 1'b1;
        RX_DATA_OUT  <= rx_rd_data;
      end else if (RX_READY_IN) begin
        RX_VALID_OUT <= 1'b0;
      end
      TX_READY_OUT <= tx_cnt_q + (AW+1)'(tx_push) + 1'b1 <= cap + (AW+1)'(tx_pop);
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      flags <= UFB_RST_FLAGS[7:3];
    end else begin
      flags.tx_empty_flag <= tx_cnt_q == '0;
      flags.rx_full_flag  <= rx_occ >= cap;
      flags.tx_full_flag  <= tx_cnt_q >= cap;
      flags.rx_empty_flag <= rx_occ == '0;
      flags.busy          <= tx_cnt_q != '0 ||
                             tx_state_q != UFB_TX_IDLE || tx_load_q;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      irq_stat_q <= '0;
      IRQ_OUT    <= 1'b0;
    end else begin
      // Hardware set wins over a write-one clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~((wr_do && aw_addr_q == UFB_OFF_IRQ_STATUS && w_strb_q[0])
                    ? w_data_q[UFB_IRQ_WIDTH-1:0] : '0))
                    | {ev_overrun, ev_rx_done, ev_tx_done};
      IRQ_OUT    <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// ===== verification/ufb_sva.sv
// Checker for bus, stream and flag relations at the top ports.
`timescale 1ns/1ps
module ufb_sva
  import ufb_pkg::*;
(
  // Clock and reset.
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  // Register bus.
  input wire logic [11:0] S_ARADDR_IN,
  input wire logic        S_ARVALID_IN,
  input wire logic        S_ARREADY_OUT,
  input wire logic [31:0] S_RDATA_OUT,
  input wire logic        S_RVALID_OUT,
  input wire logic        S_RREADY_IN,
  input wire logic [1:0]  S_BRESP_OUT,
  input wire logic        S_BVALID_OUT,
  input wire logic        S_BREADY_IN,
  // Streams and line.
  input wire logic [7:0]  RX_DATA_OUT,
  input wire logic        RX_VALID_OUT,
  input wire logic        RX_READY_IN,
  input wire logic        SER_TX_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // Remembers the read address so read data can be judged per register.
  logic [11:0] ra_q;
  always_ff @(posedge CLK_SYS_IN) if (S_ARVALID_IN && S_ARREADY_OUT) ra_q <= S_ARADDR_IN;
  wire fr = S_RVALID_OUT && (ra_q == UFB_OFF_LINE_FLAGS);
  wire rs = S_RVALID_OUT && !S_RREADY_IN;
  // ====
  // Assertions
  rst_quiet_a: assert property (disable iff (1'b0) !RST_N_IN |=> !S_BVALID_OUT && !S_RVALID_OUT && SER_TX_OUT)
    else $error("outputs not quiet after reset");
  resp_hold_a: assert property (S_BVALID_OUT && !S_BREADY_IN |=> S_BVALID_OUT && $stable(S_BRESP_OUT))
    else $error("write response dropped");
  rdata_hold_a: assert property (rs |=> S_RVALID_OUT && $stable(S_RDATA_OUT)) else $error("read data dropped");
  rx_hold_a: assert property (RX_VALID_OUT && !RX_READY_IN |=> RX_VALID_OUT && $stable(RX_DATA_OUT))
    else $error("received byte dropped");
  busy_fill_a: assert property (fr && !S_RDATA_OUT[7] |-> S_RDATA_OUT[3]) else $error("busy clear with data");
  tx_excl_a: assert property (fr |-> !(S_RDATA_OUT[7] && S_RDATA_OUT[5])) else $error("tx empty and full");
  rx_excl_a: assert property (fr |-> !(S_RDATA_OUT[6] && S_RDATA_OUT[4])) else $error("rx empty and full");
  int_rsvd_a: assert property (S_RVALID_OUT && ra_q == UFB_OFF_DIV_INTEGER |-> S_RDATA_OUT[31:16] == 16'h0)
    else $error("integer divisor upper bits set");
  frac_rsvd_a: assert property (S_RVALID_OUT && ra_q == UFB_OFF_DIV_FRACTION |-> S_RDATA_OUT[31:6] == 26'h0)
    else $error("fraction divisor upper bits set");
  cover property (fr && S_RDATA_OUT[3]);
  cover property (RX_VALID_OUT && RX_READY_IN);
  cover property (S_BVALID_OUT && S_BREADY_IN);
endmodule
bind ufb_top ufb_sva ufb_sva_i (.*);

// ===== verification/ufb_peer.sv
// Remote serial transmitter that sends eight-bit frames with one stop bit.
`timescale 1ns/1ps
module ufb_peer #(
  parameter int BIT_CLKS = 32
) (
  // Clock and line.
  input  wire logic clk_in,
  output logic      line_out
);
  // The line idles at the mark level between frames.
  initial line_out = 1'b1;
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask
endmodule

// ===== verification/tb.sv
// Testbench for flags, divisors, interrupt and line timing.
`timescale 1ns/1ps
module tb
  import ufb_pkg::*;
;
  logic        CLK_SYS_IN, RST_N_IN, S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_ARVALID_IN, S_RREADY_IN;
  logic        TX_VALID_IN, RX_READY_IN, SER_RX_IN, S_AWREADY_OUT, S_WREADY_OUT, S_BVALID_OUT;
  logic        S_ARREADY_OUT, S_RVALID_OUT, TX_READY_OUT, RX_VALID_OUT, SER_TX_OUT, IRQ_OUT;
  logic [11:0] S_AWADDR_IN, S_ARADDR_IN;
  logic [31:0] S_WDATA_IN, S_RDATA_OUT, d;
  logic [7:0]  TX_DATA_IN, RX_DATA_OUT;
  logic [3:0]  S_WSTRB_IN;
  logic [1:0]  S_BRESP_OUT, S_RRESP_OUT, r;
  int          num_errors, n_tests, n;
  ufb_top ufb_top_i (.*);
  ufb_peer #(.BIT_CLKS(32)) ufb_peer_i (.clk_in(CLK_SYS_IN), .line_out(SER_RX_IN));
  always #10 CLK_SYS_IN = ~CLK_SYS_IN;
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge CLK_SYS_IN);
    {S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_AWADDR_IN, S_WDATA_IN} <= {3'b111, a, v};
    do begin
      @(posedge CLK_SYS_IN);
      if (S_AWREADY_OUT) S_AWVALID_IN <= 1'b0;
      if (S_WREADY_OUT) S_WVALID_IN <= 1'b0;
    end while (!S_BVALID_OUT);
    S_BREADY_IN <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge CLK_SYS_IN);
    {S_ARVALID_IN, S_RREADY_IN, S_ARADDR_IN} <= {2'b11, a};
    do begin
      @(posedge CLK_SYS_IN);
      if (S_ARREADY_OUT) S_ARVALID_IN <= 1'b0;
    end while (!S_RVALID_OUT);
    d = S_RDATA_OUT;
    r = S_RRESP_OUT;
    S_RREADY_IN <= 1'b0;
  endtask
  task push(input logic [7:0] b);
    @(posedge CLK_SYS_IN);
    {TX_VALID_IN, TX_DATA_IN} <= {1'b1, b};
    do @(posedge CLK_SYS_IN); while (!TX_READY_OUT);
    TX_VALID_IN <= 1'b0;
  endtask
  // Counts the clocks of the next low stretch on the transmit line.
  task low_len();
    n = 0;
    while (SER_TX_OUT) @(posedge CLK_SYS_IN);
    while (!SER_TX_OUT) begin
      @(posedge CLK_SYS_IN);
      n++;
    end
  endtask
  task idle();
    do rd(UFB_OFF_LINE_FLAGS); while (d[UFB_BIT_BUSY]);
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge CLK_SYS_IN);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {CLK_SYS_IN, RST_N_IN, S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_ARVALID_IN, S_RREADY_IN} = '0;
    {TX_VALID_IN, RX_READY_IN, S_AWADDR_IN, S_ARADDR_IN, S_WDATA_IN, TX_DATA_IN} = '0;
    S_WSTRB_IN = 4'hf;
    repeat (6) @(posedge CLK_SYS_IN);
    RST_N_IN <= 1'b1;
    rd(UFB_OFF_LINE_FLAGS);
    chk(d, 32'h90);
    rd(UFB_OFF_DIV_INTEGER);
    chk(d, 32'h0);
    rd(UFB_OFF_DIV_FRACTION);
    chk(d, 32'h0);
    $display("reset test done");
    wr(UFB_OFF_DIV_INTEGER, 32'hffffffff);
    rd(UFB_OFF_DIV_INTEGER);
    chk(d, 32'hffff);
    wr(UFB_OFF_DIV_FRACTION, 32'hffffffff);
    rd(UFB_OFF_DIV_FRACTION);
    chk(d, 32'h3f);
    rd(12'h100);
    chk(r, UFB_RESP_SLVERR);
    wr(UFB_OFF_DIV_INTEGER, 32'h0);
    wr(UFB_OFF_DIV_FRACTION, 32'h0);
    wr(UFB_OFF_FRAME_CTRL, 32'h70);
    rd(UFB_OFF_FRAME_CTRL);
    chk(d, 32'h70);
    wr(UFB_OFF_IRQ_MASK, 32'h1);
    $display("register test done");
    push(8'hfe);
    push(8'hfe);
    low_len();
    rd(UFB_OFF_LINE_FLAGS);
    chk({d[7], d[3]}, 2'b01);
    low_len();
    chk(n, 32);
    idle();
    chk(d, 32'h90);
    chk(SER_TX_OUT, 1'b1);
    chk(IRQ_OUT, 1'b1);
    wr(UFB_OFF_IRQ_MASK, 32'h0);
    @(posedge CLK_SYS_IN);
    chk(IRQ_OUT, 1'b0);
    wr(UFB_OFF_IRQ_STATUS, 32'h7);
    wr(UFB_OFF_IRQ_MASK, 32'h1);
    chk(IRQ_OUT, 1'b0);
    $display("transmit test done");
    wr(UFB_OFF_DIV_INTEGER, 32'h2);
    push(8'hfe);
    low_len();
    chk(n, 32);
    wr(UFB_OFF_FRAME_CTRL, 32'h70);
    idle();
    push(8'hfe);
    low_len();
    chk(n, 64);
    idle();
    wr(UFB_OFF_FRAME_CTRL, 32'h60);
    push(8'h01);
    push(8'h02);
    rd(UFB_OFF_LINE_FLAGS);
    chk({d[7], d[5]}, 2'b01);
    idle();
    $display("divisor test done");
    ufb_peer_i.send(8'h5a);
    while (!RX_VALID_OUT) @(posedge CLK_SYS_IN);
    rd(UFB_OFF_LINE_FLAGS);
    chk({d[6], d[4]}, 2'b10);
    chk(RX_DATA_OUT, 8'h5a);
    RX_READY_IN <= 1'b1;
    @(posedge CLK_SYS_IN);
    RX_READY_IN <= 1'b0;
    rd(UFB_OFF_LINE_FLAGS);
    chk({d[6], d[4]}, 2'b01);
    $display("receive test done");
    report_and_stop();
  end
endmodule
